// ==== aod_hold.sv ====
`timescale 1ns/10ps
// ***************************************************************
// retriggerable pulse stretcher
// ***************************************************************
module aod_hold
  import aod_pkg::*;
  (
  input wire logic clk_sys,
  input wire logic rst,
  aod_hold_if.hold hIf
  );

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             flag;
  } aod_hold_st_t;

  aod_hold_st_t state_ff;
  aod_hold_st_t nxt_state;

  // an event reloads the full length, so events recurring within the hold length never gap
  always_comb begin
    nxt_state = state_ff;
    if (hIf.evt) begin
      nxt_state.cnt = hIf.len;
    end else if (hIf.tick && state_ff.cnt != '0) begin
      nxt_state.cnt = state_ff.cnt - CNT_W'(1);
    end
    nxt_state.flag = (nxt_state.cnt != '0);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign hIf.flag = state_ff.flag;

  holdSet_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    hIf.evt |=> hIf.flag
  ) else $error("flag not set after event");

endmodule

// ==== aod_hold_if.sv ====
`timescale 1ns/10ps
// ***************************************************************
// one hold counter: event, tick, length in, flag out
// ***************************************************************
interface aod_hold_if
  import aod_pkg::*;
  ();
  logic             evt;
  logic             tick;
  logic [CNT_W-1:0] len;
  logic             flag;

  modport ctl  (output evt, output tick, output len, input flag);
  modport hold (input evt, input tick, input len, output flag);
endinterface

// ==== aod_pkg.sv ====
// ***************************************************************
// widths and counts
// ***************************************************************
package aod_pkg;

  localparam int SAMPLE_W   = 12;  // converted sample, two's complement
  localparam int ABS_W      = 11;  // magnitude without sign
  localparam int CMP_W      = 8;   // upper magnitude bits compared
  localparam int DEC_W      = 16;  // decimated output word
  localparam int HOLD_SEL_W = 3;
  localparam int MODE_W     = 5;
  localparam int CNT_W      = 11;  // holds 1024
  localparam int NUM_PIN    = 4;   // a high, a low, b high, b low
  localparam int NUM_HOLD   = 8;   // pin flags then embedded flags
  localparam int ADR_W      = 8;
  localparam int DAT_W      = 32;
  localparam int SEL_W      = 4;

  // ***************************************************************
  // hold lengths and sample constants
  // ***************************************************************
  localparam logic [CNT_W-1:0]    PIN_HOLD_BASE = 11'h008; // setting 0
  localparam logic [CNT_W-1:0]    EMB_HOLD_BASE = 11'h001; // 2 to the 0
  localparam logic [SAMPLE_W-1:0] SAMP_MIN      = 12'h800; // -2048
  localparam logic [ABS_W-1:0]    ABS_MAX       = 11'h7FF; // 2047
  localparam logic [SAMPLE_W-1:0] SAMP_ONE      = 12'h001;
  localparam logic [3:0]          SHIFT_ONE     = 4'h1;

  // ***************************************************************
  // link mode codes that decide which modes carry embedded flags (0C is excluded)
  // ***************************************************************
  localparam logic [MODE_W-1:0] MODE_REAL_DEC   = 5'h09;
  localparam logic [MODE_W-1:0] MODE_CPLX_FIRST = 5'h0A;
  localparam logic [MODE_W-1:0] MODE_CPLX_LAST  = 5'h10;
  localparam logic [MODE_W-1:0] MODE_CPLX_SKIP  = 5'h0C;

  typedef enum logic [1:0] {
    EMB_NONE = 2'b00,
    EMB_REAL = 2'b01,
    EMB_CPLX = 2'b10
  } aod_emb_t;

  // ***************************************************************
  // register map, fields and reset values
  // ***************************************************************
  localparam logic [ADR_W-1:0] ADR_CTRL  = 8'h00;
  localparam logic [ADR_W-1:0] ADR_THR   = 8'h04;
  localparam logic [ADR_W-1:0] ADR_FLAGS = 8'h08;
  localparam logic [ADR_W-1:0] ADR_ISTAT = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_IMASK = 8'h10;

  localparam int CTRL_HOLD_LSB = 0;
  localparam int CTRL_MODE_LSB = 8;
  localparam int THR_HIGH_LSB  = 0;
  localparam int THR_LOW_LSB   = 8;

  localparam logic [CMP_W-1:0]      HIGH_THR_RST = 8'hFF;
  localparam logic [CMP_W-1:0]      LOW_THR_RST  = 8'hFF;
  localparam logic [HOLD_SEL_W-1:0] HOLD_SEL_RST = 3'h0;
  localparam logic [MODE_W-1:0]     MODE_RST     = 5'h00;

endpackage

// ==== aod_top.sv ====
`timescale 1ns/10ps
// Function
// - compare upper eight magnitude bits against thresholds
// - both channels share one threshold pair
// - magnitude saturates, -2048 and +2047 give 2047
// - flag high when magnitude reaches threshold
// - suffix 0 high threshold, suffix 1 low
// - hold 8 cycles doubling to 1024
// - embed only in decimating one-control-bit modes
// - complex: I carries high flag, Q low
// - real: even sample high flag, odd low
// - real mode period two to setting plus one
// - complex modes period two to setting samples
module aod_top
  import aod_pkg::*;
  (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [SEL_W-1:0] sel_i,
  input  wire logic [DAT_W-1:0] dat_i,
  output wire logic [DAT_W-1:0] dat_o,
  output wire logic             ack_o,
  output wire logic             irq_o,
  input  wire logic             rawValid,
  input  wire logic [SAMPLE_W-1:0] rawA,
  input  wire logic [SAMPLE_W-1:0] rawB,
  input  wire logic             decValid,
  input  wire logic             decIsQ,
  input  wire logic [DEC_W-1:0] decA,
  input  wire logic [DEC_W-1:0] decB,
  output wire logic             outValid,
  output wire logic [DEC_W-1:0] outA,
  output wire logic [DEC_W-1:0] outB,
  output wire logic             chanAHighFlag,
  output wire logic             chanALowFlag,
  output wire logic             chanBHighFlag,
  output wire logic             chanBLowFlag
  );

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic                  ack;
    logic [DAT_W-1:0]      rdat;
    logic                  irq;
    logic [HOLD_SEL_W-1:0] holdLengthSelect;
    logic [MODE_W-1:0]     linkModeSelect;
    logic [CMP_W-1:0]      highThreshold;
    logic [CMP_W-1:0]      lowThreshold;
    logic [NUM_PIN-1:0]    istat;
    logic [NUM_PIN-1:0]    imask;
    logic [CMP_W-1:0]      upA;
    logic [CMP_W-1:0]      upB;
    logic                  absValid;
    logic [DEC_W-1:0]      outA;
    logic [DEC_W-1:0]      outB;
    logic                  outValid;
  } aod_top_st_t;

  localparam aod_top_st_t ST_RST = '{
    highThreshold:    HIGH_THR_RST,
    lowThreshold:     LOW_THR_RST,
    holdLengthSelect: HOLD_SEL_RST,
    linkModeSelect:   MODE_RST,
    default:          '0
  };

  aod_top_st_t         state_ff;
  aod_top_st_t         nxt_state;
  logic [NUM_HOLD-1:0] evt;
  logic [NUM_HOLD-1:0] holdFlag;
  logic [CNT_W-1:0]    pinLen;
  logic [CNT_W-1:0]    embLen;
  aod_emb_t            embKind;
  logic                reqNew;
  logic                wrNow;
  logic [DAT_W-1:0]    readMux;

  // ***************************************************************
  // helpers
  // ***************************************************************

  // saturate -2048 so both extremes land on the same code
  function automatic logic [CMP_W-1:0] absUpper(
    input logic [SAMPLE_W-1:0] s
  );
    logic [SAMPLE_W-1:0] neg;
    logic [ABS_W-1:0]    mag;
    neg = ~s + SAMP_ONE;
    if (s == SAMP_MIN) begin
      mag = ABS_MAX;
    end else if (s[SAMPLE_W-1]) begin
      mag = neg[ABS_W-1:0];
    end else begin
      mag = s[ABS_W-1:0];
    end
    return mag[ABS_W-1 -: CMP_W];
  endfunction

  // byte-lane merge for partial wishbone writes
  function automatic logic [DAT_W-1:0] laneMerge(
    input logic [DAT_W-1:0] oldV,
    input logic [DAT_W-1:0] newV,
    input logic [SEL_W-1:0] sel
  );
    logic [DAT_W-1:0] res;
    res = oldV;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ***************************************************************
  // threshold compare and hold lengths
  // ***************************************************************

  // one threshold pair serves both channels
  assign evt[0] = state_ff.absValid
                  && state_ff.upA >= state_ff.highThreshold;
  assign evt[1] = state_ff.absValid
                  && state_ff.upA >= state_ff.lowThreshold;
  assign evt[2] = state_ff.absValid
                  && state_ff.upB >= state_ff.highThreshold;
  assign evt[3] = state_ff.absValid
                  && state_ff.upB >= state_ff.lowThreshold;
  assign evt[NUM_HOLD-1:NUM_PIN] = evt[NUM_PIN-1:0];

  // pin hold in clock cycles, embedded hold in converter samples
  assign pinLen = PIN_HOLD_BASE << state_ff.holdLengthSelect;

  always_comb begin
    embKind = EMB_NONE;
    embLen  = EMB_HOLD_BASE << state_ff.holdLengthSelect;
    if (state_ff.linkModeSelect == MODE_REAL_DEC) begin
      embKind = EMB_REAL;
      embLen  = EMB_HOLD_BASE
                << ({1'b0, state_ff.holdLengthSelect} + SHIFT_ONE);
    end else if (state_ff.linkModeSelect >= MODE_CPLX_FIRST
                 && state_ff.linkModeSelect <= MODE_CPLX_LAST
                 && state_ff.linkModeSelect != MODE_CPLX_SKIP) begin
      embKind = EMB_CPLX;
    end
  end

  // ***************************************************************
  // hold counters
  // ***************************************************************
  aod_hold_if hIf[NUM_HOLD] ();

  for (genvar gi = 0; gi < NUM_HOLD; gi++) begin : gHold
    assign hIf[gi].evt  = evt[gi];
    assign holdFlag[gi] = hIf[gi].flag;
    if (gi < NUM_PIN) begin : gPin
      assign hIf[gi].tick = 1'b1;
      assign hIf[gi].len  = pinLen;
    end else begin : gEmb
      assign hIf[gi].tick = state_ff.absValid;
      assign hIf[gi].len  = embLen;
    end
    aod_hold uHold (
      .clk_sys (clk_sys),
      .rst     (rst),
      .hIf     (hIf[gi])
    );
  end

  // ***************************************************************
  // wishbone slave
  // ***************************************************************

  // ack one cycle after the strobe, writes land on the acked edge
  assign reqNew = cyc_i && stb_i && !state_ff.ack;
  assign wrNow  = cyc_i && stb_i && we_i && state_ff.ack;

  // unmapped addresses still ack and read as zero
  always_comb begin
    readMux = '0;
    unique case (adr_i)
      ADR_CTRL: begin
        readMux[CTRL_HOLD_LSB +: HOLD_SEL_W] = state_ff.holdLengthSelect;
        readMux[CTRL_MODE_LSB +: MODE_W]     = state_ff.linkModeSelect;
      end
      ADR_THR: begin
        readMux[THR_HIGH_LSB +: CMP_W] = state_ff.highThreshold;
        readMux[THR_LOW_LSB +: CMP_W]  = state_ff.lowThreshold;
      end
      ADR_FLAGS: readMux[NUM_HOLD-1:0] = holdFlag;
      ADR_ISTAT: readMux[NUM_PIN-1:0]  = state_ff.istat;
      ADR_IMASK: readMux[NUM_PIN-1:0]  = state_ff.imask;
      default:   readMux = '0;
    endcase
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic [DAT_W-1:0] wv;
    logic [NUM_PIN-1:0] clr;
    wv        = '0;
    clr       = '0;
    nxt_state = state_ff;

    // bus handshake
    nxt_state.ack = reqNew;
    if (reqNew) begin
      nxt_state.rdat = readMux;
    end

    if (wrNow) begin
      wv = laneMerge(readMux, dat_i, sel_i);
      unique case (adr_i)
        ADR_CTRL: begin
          nxt_state.holdLengthSelect = wv[CTRL_HOLD_LSB +: HOLD_SEL_W];
          nxt_state.linkModeSelect   = wv[CTRL_MODE_LSB +: MODE_W];
        end
        ADR_THR: begin
          nxt_state.highThreshold = wv[THR_HIGH_LSB +: CMP_W];
          nxt_state.lowThreshold  = wv[THR_LOW_LSB +: CMP_W];
        end
        ADR_ISTAT: clr = dat_i[NUM_PIN-1:0] & {NUM_PIN{sel_i[0]}};
        ADR_IMASK: nxt_state.imask = wv[NUM_PIN-1:0];
        default: ;
      endcase
    end

    // a new event wins over a write-one clear in the same cycle
    nxt_state.istat = (state_ff.istat & ~clr) | evt[NUM_PIN-1:0];
    nxt_state.irq   = |(nxt_state.istat & nxt_state.imask);

    // magnitude stage, one sample pair per valid
    nxt_state.absValid = rawValid;
    if (rawValid) begin
      nxt_state.upA = absUpper(rawA);
      nxt_state.upB = absUpper(rawB);
    end

    // lsb replacement keeps the word width; high flag on I or even
    nxt_state.outValid = decValid;
    if (decValid) begin
      unique case (embKind)
        EMB_NONE: begin
          nxt_state.outA = decA;
          nxt_state.outB = decB;
        end
        EMB_REAL, EMB_CPLX: begin
          nxt_state.outA = {decA[DEC_W-1:1],
                            decIsQ ? holdFlag[5] : holdFlag[4]};
          nxt_state.outB = {decB[DEC_W-1:1],
                            decIsQ ? holdFlag[7] : holdFlag[6]};
        end
        default: begin
          nxt_state.outA = decA;
          nxt_state.outB = decB;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= ST_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign dat_o         = state_ff.rdat;
  assign ack_o         = state_ff.ack;
  assign irq_o         = state_ff.irq;
  assign outValid      = state_ff.outValid;
  assign outA          = state_ff.outA;
  assign outB          = state_ff.outB;
  assign chanAHighFlag = holdFlag[0];
  assign chanALowFlag  = holdFlag[1];
  assign chanBHighFlag = holdFlag[2];
  assign chanBLowFlag  = holdFlag[3];

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  absSat_a: assert property (
    rawValid && rawA == SAMP_MIN |=> state_ff.upA == ABS_MAX[ABS_W-1 -: CMP_W]
  ) else $error("most negative sample not saturated");

  highCmp_a: assert property (
    state_ff.absValid && state_ff.upA >= state_ff.highThreshold
    |=> chanAHighFlag
  ) else $error("channel a high flag missed");

  sharedThr_a: assert property (
    state_ff.absValid && state_ff.upB >= state_ff.highThreshold
    |=> chanBHighFlag
  ) else $error("channel b high flag missed");

  lowSuffix_a: assert property (
    state_ff.absValid && state_ff.upB >= state_ff.lowThreshold
    |=> chanBLowFlag
  ) else $error("channel b low flag missed");

  holdEight_a: assert property (
    $fell(chanAHighFlag) && $past(state_ff.holdLengthSelect, 9) == '0
    && state_ff.holdLengthSelect == '0 |-> $past(evt[0], 9)
  ) else $error("hold length wrong at setting zero");

  holdRestart_a: assert property (
    evt[0] |=> chanAHighFlag [*8]
  ) else $error("flag dropped inside hold");

  cplxEmbed_a: assert property (
    decValid && embKind == EMB_CPLX && !decIsQ
    |=> outA == {$past(decA[DEC_W-1:1]), $past(holdFlag[4])}
  ) else $error("I word lacks high flag");

  realOdd_a: assert property (
    decValid && embKind == EMB_REAL && decIsQ
    |=> outB[0] == $past(holdFlag[7])
  ) else $error("odd sample lacks low flag");

  passThru_a: assert property (
    decValid && embKind == EMB_NONE |=> outA == $past(decA)
  ) else $error("flag embedded in plain mode");

  realPeriod_a: assert property (
    (evt[4] && embKind == EMB_REAL && state_ff.holdLengthSelect == '0)
    ##1 (!evt[4] && state_ff.absValid) |=> holdFlag[4]
  ) else $error("real period shorter than two samples");

  cplxPeriod_a: assert property (
    (evt[4] && embKind == EMB_CPLX && state_ff.holdLengthSelect == '0)
    ##1 (!evt[4] && state_ff.absValid && embKind == EMB_CPLX
    && state_ff.holdLengthSelect == '0) |=> !holdFlag[4]
  ) else $error("complex period longer than one sample");

  irqLevel_a: assert property (
    irq_o == ((state_ff.istat & state_ff.imask) != '0)
  ) else $error("interrupt output out of step");

  cplxEvt_c: cover property (evt[0] && embKind == EMB_CPLX);
  irqSeen_c: cover property ($rose(irq_o));
  flagFell_c: cover property ($fell(chanBLowFlag));
  ctrlWrite_c: cover property (wrNow && adr_i == ADR_CTRL);

endmodule

// ==== aod_watcher.sv ====
`timescale 1ns/10ps
// ***************************************************************
// downstream gain watcher
// ***************************************************************
module aod_watcher #(
  parameter int QUIET = 64  // quiet cycles before gain may rise
  ) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic chanAHighFlag,
  input  wire logic chanALowFlag,
  input  wire logic chanBHighFlag,
  input  wire logic chanBLowFlag,
  output wire logic orHigh,
  output wire logic orLow,
  output wire logic gainDown,
  output wire logic gainUp
  );
  logic [15:0] quietCnt;

  // single channel: either core may catch the peak, so merge them
  assign orHigh   = chanAHighFlag | chanBHighFlag;
  assign orLow    = chanALowFlag | chanBLowFlag;
  // high threshold sits near full scale: cut gain at once
  assign gainDown = orHigh;
  // low threshold silent for long means a weak input
  always @(posedge clk_sys) begin
    if (rst || orLow) begin
      quietCnt <= 16'h0000;
    end else if (quietCnt != 16'hFFFF) begin
      quietCnt <= quietCnt + 16'h0001;
    end
  end
  assign gainUp = (quietCnt >= 16'(QUIET));
endmodule

// ==== test_adc_overrange_detector.sv ====
`timescale 1ns/10ps
module test_adc_overrange_detector
  import aod_pkg::*;
  ;
  logic clk_sys, rst, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [ADR_W-1:0] adr_i;
  logic [SEL_W-1:0] sel_i;
  logic [DAT_W-1:0] dat_i, dat_o;
  logic rawValid, decValid, decIsQ, outValid;
  logic [SAMPLE_W-1:0] rawA, rawB;
  logic [DEC_W-1:0] decA, decB, outA, outB;
  logic aH, aL, bH, bL, orHigh, orLow;
  logic [3:0] pinFlags;
  int nMismatch = 0;
  int checks = 0;

  assign pinFlags = {aH, aL, bH, bL};

  aod_top dut_u (.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .rawValid(rawValid), .rawA(rawA), .rawB(rawB),
    .decValid(decValid), .decIsQ(decIsQ), .decA(decA), .decB(decB),
    .outValid(outValid), .outA(outA), .outB(outB),
    .chanAHighFlag(aH), .chanALowFlag(aL), .chanBHighFlag(bH),
    .chanBLowFlag(bL));

  aod_watcher watch_u (.clk_sys(clk_sys), .rst(rst),
    .chanAHighFlag(aH), .chanALowFlag(aL), .chanBHighFlag(bH),
    .chanBLowFlag(bL), .orHigh(orHigh), .orLow(orLow),
    .gainDown(), .gainUp());

  // ***************************************************************
  // shared helpers
  // ***************************************************************
  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg,
               got, exp);
    end
  endtask

  // one classic cycle; released only at the edge that sees ack
  task automatic wbXfer(input logic we, input logic [ADR_W-1:0] adr,
                        input logic [DAT_W-1:0] wd,
                        output logic [DAT_W-1:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= we;
    adr_i <= adr;
    dat_i <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack_o !== 1'h1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    if (n >= 50) begin
      nMismatch++;
      $display("unexpected at %0t: no bus ack", $time);
      finishTest();
    end
  endtask

  // returns just after the edge that takes the sample
  task automatic rawSend(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk_sys);
    rawValid <= 1'h1;
    rawA     <= a;
    rawB     <= b;
    @(posedge clk_sys);
    rawValid <= 1'h0;
  endtask

  // a words carry lsb 0 on I and 1 on Q, b words the reverse
  task automatic decCheck(input logic q, input logic ea,
                          input logic eb, input logic pass);
    logic [15:0] wa;
    logic [15:0] wb;
    wa = q ? 16'h3C3D : 16'hA5A4;
    wb = q ? 16'hC3C2 : 16'h5A5B;
    @(posedge clk_sys);
    decValid <= 1'h1;
    decIsQ   <= q;
    decA     <= wa;
    decB     <= wb;
    @(posedge clk_sys);
    decValid <= 1'h0;
    #1;
    cmp(32'(outValid), 32'h1, "out valid");
    if (pass) cmp(32'({outA, outB}), 32'({wa, wb}), "pass word");
    else cmp(32'({outA, outB}), 32'({wa[15:1], ea, wb[15:1], eb}),
             "embedded word");
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic testRegs();
    logic [31:0] d;
    wbXfer(1'h0, ADR_CTRL, 32'h0, d);
    cmp(d, 32'h0, "ctrl reset");
    wbXfer(1'h0, ADR_THR, 32'h0, d);
    cmp(d, {16'h0, LOW_THR_RST, HIGH_THR_RST}, "threshold reset");
    wbXfer(1'h0, ADR_IMASK, 32'h0, d);
    cmp(d, 32'h0, "mask reset");
    wbXfer(1'h1, 8'h40, 32'hFFFFFFFF, d);
    wbXfer(1'h0, 8'h40, 32'h0, d);
    cmp(d, 32'h0, "unmapped read");
    $display("test registers done");
  endtask

  // both channels share thresholds high 255, low 254
  task automatic testMagnitude();
    logic [31:0] d;
    logic [11:0] sa[4] = '{12'h7FF, 12'h000, 12'h7F0, 12'h7EF};
    logic [11:0] sb[4] = '{12'h000, 12'h800, 12'h810, 12'h811};
    logic [3:0]  ex[4] = '{4'hC, 4'h3, 4'h5, 4'h0};
    wbXfer(1'h1, ADR_THR, 32'h0000FEFF, d);
    foreach (sa[i]) begin
      rawSend(sa[i], sb[i]);
      repeat (2) @(posedge clk_sys);
      #1;
      cmp(32'(pinFlags), 32'(ex[i]), "pin flags");
      cmp(32'({orHigh, orLow}), 32'({ex[i][3] | ex[i][1],
          ex[i][2] | ex[i][0]}), "merged flags");
      repeat (12) @(posedge clk_sys);
    end
    $display("test magnitude done");
  endtask

  task automatic holdLen(output int n);
    n = 0;
    while (aH === 1'h1 && n < 2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 2000) begin
      nMismatch++;
      $display("unexpected at %0t: flag never dropped", $time);
      finishTest();
    end
  endtask

  task automatic testHold();
    logic [31:0] d;
    int hs[3] = '{0, 3, 7};
    int n;
    int lost;
    wbXfer(1'h1, ADR_THR, 32'h000040E4, d);
    foreach (hs[i]) begin
      wbXfer(1'h1, ADR_CTRL, 32'(hs[i]), d);
      rawSend(12'h7FF, 12'h000);
      // first look is in the first high cycle, so holdLen counts all
      repeat (1) @(posedge clk_sys);
      #1;
      holdLen(n);
      cmp(32'(n), 32'(8 << hs[i]), "hold length");
    end
    // events 6 then 4 cycles apart must keep the flag up throughout
    wbXfer(1'h1, ADR_CTRL, 32'h0, d);
    lost = 0;
    rawSend(12'h7FF, 12'h000);
    repeat (2) @(posedge clk_sys);
    repeat (4) begin
      repeat (2) begin
        @(posedge clk_sys);
        #1;
        lost += (aH !== 1'h1);
      end
      rawSend(12'h7FF, 12'h000);
      #1;
      lost += (aH !== 1'h1);
    end
    cmp(32'(lost), 32'h0, "flag gap");
    repeat (1) @(posedge clk_sys);
    #1;
    holdLen(n);
    cmp(32'(n), 32'h8, "hold after last");
    $display("test hold done");
  endtask

  // a-low event only: status bit 1, masked then unmasked
  task automatic testIrq();
    logic [31:0] d;
    wbXfer(1'h1, ADR_THR, 32'h0000FEFF, d);
    wbXfer(1'h1, ADR_ISTAT, 32'h0000000F, d);
    rawSend(12'h7F0, 12'h000);
    repeat (4) @(posedge clk_sys);
    wbXfer(1'h0, ADR_ISTAT, 32'h0, d);
    #1;
    cmp(d, 32'h2, "event status");
    cmp(32'(irq_o), 32'h0, "irq masked");
    wbXfer(1'h1, ADR_IMASK, 32'h1, d);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp(32'(irq_o), 32'h0, "irq other bit");
    wbXfer(1'h1, ADR_IMASK, 32'h2, d);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp(32'(irq_o), 32'h1, "irq raised");
    wbXfer(1'h1, ADR_ISTAT, 32'h1, d);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp(32'(irq_o), 32'h1, "irq wrong clear");
    wbXfer(1'h1, ADR_ISTAT, 32'h2, d);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp(32'(irq_o), 32'h0, "irq cleared");
    $display("test interrupt done");
  endtask

  // a: 254 trips high only; b: 255 trips both; hold select 1
  task automatic testEmbed();
    logic [31:0] d;
    logic [4:0] md[7] = '{5'h09, 5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F,
                          5'h10};
    logic [4:0] pm[3] = '{5'h00, 5'h05, 5'h0C};
    int p;
    wbXfer(1'h1, ADR_THR, 32'h0000FFF0, d);
    foreach (md[i]) begin
      p = (md[i] == MODE_REAL_DEC) ? 4 : 2;
      wbXfer(1'h1, ADR_CTRL, {19'h0, md[i], 8'h01}, d);
      rawSend(12'h7F0, 12'h7FF);
      repeat (p - 1) rawSend(12'h000, 12'h000);
      repeat (3) @(posedge clk_sys);
      decCheck(1'h0, 1'h1, 1'h1, 1'h0);
      decCheck(1'h1, 1'h0, 1'h1, 1'h0);
      repeat (2) rawSend(12'h000, 12'h000);
      repeat (3) @(posedge clk_sys);
      decCheck(1'h0, 1'h0, 1'h0, 1'h0);
      decCheck(1'h1, 1'h0, 1'h0, 1'h0);
    end
    // back-to-back samples at setting 0: the quiet sample ends the
    // one-sample complex window, the two-sample real window survives
    for (int k = 0; k < 2; k++) begin
      wbXfer(1'h1, ADR_CTRL, {19'h0, md[k], 8'h00}, d);
      @(posedge clk_sys);
      rawValid <= 1'h1;
      rawA     <= 12'h7F0;
      rawB     <= 12'h7FF;
      @(posedge clk_sys);
      rawA     <= 12'h000;
      rawB     <= 12'h000;
      @(posedge clk_sys);
      rawValid <= 1'h0;
      repeat (3) @(posedge clk_sys);
      decCheck(1'h0, k == 0, k == 0, 1'h0);
    end
    foreach (pm[i]) begin
      wbXfer(1'h1, ADR_CTRL, {19'h0, pm[i], 8'h01}, d);
      // most negative code on a exercises the saturating magnitude
      rawSend(12'h800, 12'h7FF);
      repeat (3) @(posedge clk_sys);
      decCheck(1'h0, 1'h0, 1'h0, 1'h1);
      decCheck(1'h1, 1'h0, 1'h0, 1'h1);
    end
    $display("test embedding done");
  endtask

  // ***************************************************************
  // clock, reset and sequence
  // ***************************************************************
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    rst      = 1'h1;
    cyc_i    = 1'h0;
    stb_i    = 1'h0;
    we_i     = 1'h0;
    adr_i    = 8'h00;
    sel_i    = 4'hF;
    dat_i    = 32'h0;
    rawValid = 1'h0;
    rawA     = 12'h000;
    rawB     = 12'h000;
    decValid = 1'h0;
    decIsQ   = 1'h0;
    decA     = 16'h0000;
    decB     = 16'h0000;
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    testRegs();
    testMagnitude();
    testHold();
    testIrq();
    testEmbed();
    finishTest();
  end
endmodule
